// ==== design/drd_ctl.sv ====
// Purpose: controller end: makes the link clock, sequences commands, moves data
// Assumes: runs on i_ref_clk; link beat clock is i_ref_clk divided by two
// Notes: write data passes a FIFO; read data has no back-pressure
`timescale 1ns/1ps

module drd_fifo import drd_pkg::*; #(
  parameter int WIDTH = DQ_W + 1,
  parameter int DEPTH = DEF_FIFO_DEPTH
) (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire logic i_valid,
  output logic o_ready,
  input wire logic [WIDTH-1:0] i_data,
  output logic o_valid,
  input wire logic i_ready,
  output logic [WIDTH-1:0] o_data,
  output logic [$clog2(DEPTH):0] o_count
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } drd_fifo_s_t;
  drd_fifo_s_t q;
  drd_fifo_s_t d;
  logic push;
  logic pop;

  // pointers wrap naturally; depth must be a power of two
  always_comb begin
    d = q;
    o_ready = (q.cnt != (AW + 1)'(DEPTH));
    o_valid = (q.cnt != '0);
    push = i_valid && o_ready;
    pop = i_ready && o_valid;
    if (push) begin
      d.mem[q.wp] = i_data;
      d.wp = q.wp + AW'(1);
    end
    if (pop) begin
      d.rp = q.rp + AW'(1);
    end
    d.cnt = q.cnt + (AW + 1)'(push) - (AW + 1)'(pop);
    if (i_rst) begin
      d = '0;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_ce) begin
      q <= d;
    end
  end

  assign o_data = q.mem[q.rp];
  assign o_count = q.cnt;
endmodule

module drd_ctl import drd_pkg::*; #(
  parameter int FIFO_DEPTH = DEF_FIFO_DEPTH
) (
  drd_link_if.ctl lk,
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire logic i_req_valid,
  output logic o_req_ready,
  input wire logic i_req_wr,
  input wire logic i_req_rank,
  input wire logic [BA_W-1:0] i_req_bank,
  input wire logic [ADDR_W-1:0] i_req_row,
  input wire logic [COL_W-1:0] i_req_col,
  input wire logic i_wd_valid,
  output logic o_wd_ready,
  input wire logic [DQ_W-1:0] i_wd_data,
  input wire logic i_wd_mask,
  output logic o_rd_valid,
  output logic [DQ_W-1:0] o_rd_data,
  input wire logic i_x8,
  input wire logic i_tdqs_en,
  input wire logic i_interleave,
  input wire logic i_hot,
  output logic o_init_done
);
  localparam int FCW = $clog2(FIFO_DEPTH) + 1;
  typedef struct packed {
    logic lclk;
    logic ck;
    drd_ctl_st_t st;
    logic [1:0] mri;
    logic [3:0] gap;
    logic [4:0] k;
    logic [2:0] rcnt;
    logic wr;
    logic rank;
    logic [BA_W-1:0] ba;
    logic [ADDR_W-1:0] row;
    logic [COL_W-1:0] col;
    logic [RANKS*BANKS-1:0] open;
    logic [RANKS*BANKS-1:0][ADDR_W-1:0] orow;
    logic [9:0] refc;
    logic ref_due;
    logic hot_d;
    logic [1:0] cs_n;
    logic [2:0] cmd;
    logic [BA_W-1:0] bao;
    logic [ADDR_W-1:0] addr;
    logic [DQ_W-1:0] dq;
    logic dq_oe;
    logic dqs;
    logic dqs_oe;
    logic dm;
    logic [DQ_W-1:0] s1dq;
    logic [DQ_W-1:0] s2dq;
    logic s1s;
    logic s2s;
    logic sprev;
    logic rd_valid;
    logic [DQ_W-1:0] rd_data;
  } drd_ctl_s_t;
  drd_ctl_s_t q;
  drd_ctl_s_t d;
  logic fall;
  logic issue;
  logic pop;
  logic take;
  logic wbeat;
  logic [3:0] ri;
  logic [3:0] ci;
  logic [DQ_W:0] fdata;
  logic [FCW-1:0] fcnt;

  drd_fifo #(.WIDTH(DQ_W + 1), .DEPTH(FIFO_DEPTH)) u_wfifo (
    .i_ref_clk(i_ref_clk),
    .i_rst(i_rst),
    .i_ce(i_ce),
    .i_valid(i_wd_valid),
    .o_ready(o_wd_ready),
    .i_data({i_wd_mask, i_wd_data}),
    .o_valid(),
    .i_ready(pop),
    .o_data(fdata),
    .o_count(fcnt)
  );

  // a write is taken only with a whole burst already buffered
  assign o_req_ready = (q.st == C_IDLE) && !q.ref_due && (q.hot_d == i_hot) &&
                       (!i_req_wr || fcnt >= FCW'(BURST));
  assign take = o_req_ready && i_req_valid;
  assign fall = q.lclk; // link clock falls at this edge
  assign wbeat = (q.k >= WL_BEATS) && (q.k < WL_BEATS + 5'h08);
  assign pop = fall && (q.st == C_DATA) && q.wr && wbeat;

  always_comb begin
    d = q;
    d.lclk = ~q.lclk; // divider makes the link clock; see R05
    issue = fall && !q.ck && (q.gap == 4'h0);
    ri = {i_req_rank, i_req_bank};
    ci = {q.rank, q.ba};
    d.rd_valid = 1'b0;
    // read pins cross through two stages before use
    d.s1dq = lk.dq;
    d.s2dq = q.s1dq;
    d.s1s = lk.dqs;
    d.s2s = q.s1s;
    d.sprev = q.s2s;
    // refresh timer; hot case halves the interval; see R09
    if (q.refc == 10'h000) begin
      d.ref_due = 1'b1;
      d.refc = i_hot ? REFI_HOT_CYC : REFI_CYC;
    end else begin
      d.refc = q.refc - 10'h001;
    end
    // commands last one beat and change half a beat before device sampling
    if (fall) begin
      d.ck = ~q.ck;
      d.cs_n = CS_NONE;
      d.cmd = CMD_NOP;
      if (q.gap != 4'h0) begin
        d.gap = q.gap - 4'h1;
      end
    end else if (q.dqs_oe) begin
      d.dqs = ~q.dqs; // strobe edge mid-beat; see R02
    end
    unique case (q.st)
      C_INIT: begin
        if (issue) begin
          d.cs_n = CS_BOTH;
          d.cmd = CMD_MRS;
          d.bao = {1'b0, q.mri};
          d.addr = '0;
          if (q.mri == 2'h0) begin
            d.addr[MR_ORDER_BIT] = i_interleave;
          end else if (q.mri == 2'h1) begin
            d.addr[MR_TDQS_BIT] = i_tdqs_en && i_x8;
          end else begin
            d.addr[MR_SRT_BIT] = i_hot; // see R09
            d.hot_d = i_hot;
            d.st = C_IDLE;
          end
          d.mri = q.mri + 2'h1;
          d.gap = GAP_BEATS;
        end
      end
      C_IDLE: begin
        if (take) begin
          d.wr = i_req_wr;
          d.rank = i_req_rank;
          d.ba = i_req_bank;
          d.row = i_req_row;
          d.col = i_req_col;
          // open-row record per bank of each rank; see R16
          if (!q.open[ri]) begin
            d.st = C_ACT;
          end else if (q.orow[ri] == i_req_row) begin
            d.st = C_COL;
          end else begin
            d.st = C_PRE;
          end
        end else if (issue && (q.ref_due || q.hot_d != i_hot)) begin
          d.cs_n = CS_BOTH;
          d.cmd = CMD_PRE;
          d.addr = '0;
          d.addr[A10_BIT] = 1'b1;
          d.open = '0;
          d.st = C_REF;
          d.gap = GAP_BEATS;
        end
      end
      C_PRE: begin
        if (issue) begin
          d.cs_n = q.rank ? 2'h1 : 2'h2;
          d.cmd = CMD_PRE;
          d.bao = q.ba;
          d.addr = '0;
          d.open[ci] = 1'b0;
          d.st = C_ACT;
          d.gap = GAP_BEATS;
        end
      end
      C_ACT: begin
        if (issue) begin
          d.cs_n = q.rank ? 2'h1 : 2'h2;
          d.cmd = CMD_ACT; // see R07
          d.bao = q.ba;
          d.addr = q.row;
          d.open[ci] = 1'b1;
          d.orow[ci] = q.row; // see R16
          d.st = C_COL;
          d.gap = GAP_BEATS;
        end
      end
      C_COL: begin
        if (issue) begin
          d.cs_n = q.rank ? 2'h1 : 2'h2; // see R08
          d.cmd = q.wr ? CMD_WR : CMD_RD;
          d.bao = q.ba;
          d.addr = ADDR_W'(q.col);
          d.k = 5'h00;
          d.rcnt = 3'h0;
          d.dqs = 1'b0;
          d.st = C_DATA;
          d.gap = GAP_BEATS;
        end
      end
      C_DATA: begin
        if (q.wr) begin
          if (fall) begin
            d.k = q.k + 5'h01;
            if (wbeat) begin
              d.dq = fdata[DQ_W-1:0]; // see R05 R11
              d.dm = fdata[DQ_W];
              d.dq_oe = 1'b1;
              d.dqs_oe = 1'b1;
            end else if (q.k == WL_BEATS + 5'h08) begin
              d.dq_oe = 1'b0;
              d.dqs_oe = 1'b0;
              d.dm = 1'b0;
              d.st = C_IDLE;
            end
          end
        end else if (q.s2s != q.sprev) begin
          // each strobe transition carries one read beat; see R05
          d.rd_valid = 1'b1;
          d.rd_data = q.s2dq;
          d.rcnt = q.rcnt + 3'h1;
          if (q.rcnt == 3'h7) begin
            d.st = C_IDLE;
          end
        end
      end
      C_REF: begin
        if (issue) begin
          d.cs_n = CS_BOTH;
          d.cmd = CMD_REF;
          d.ref_due = 1'b0;
          d.mri = 2'h2;
          d.st = (q.hot_d != i_hot) ? C_INIT : C_IDLE;
          d.gap = GAP_BEATS;
        end
      end
    endcase
    // the link clock keeps running in reset so the far end can reset too
    if (i_rst) begin
      d = '0;
      // an unknown phase at power-up resolves to a rise, so the divider always starts
      d.lclk = 1'b1;
      if (q.lclk) begin
        d.lclk = 1'b0;
      end
      d.cs_n = CS_NONE;
      d.cmd = CMD_NOP;
      d.refc = REFI_CYC;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_ce) begin
      q <= d;
    end
  end

  assign lk.dck = q.lclk;
  assign lk.ck = q.ck;
  assign lk.cs_n = q.cs_n;
  assign {lk.ras_n, lk.cas_n, lk.we_n} = q.cmd;
  assign lk.ba = q.bao;
  assign lk.addr = q.addr;
  assign lk.dm = q.dm;
  assign lk.ctl_dq = q.dq;
  assign lk.ctl_dq_oe = {DQ_W{q.dq_oe}};
  assign lk.ctl_dqs = q.dqs;
  assign lk.ctl_dqs_oe = q.dqs_oe;
  assign o_rd_valid = q.rd_valid;
  assign o_rd_data = q.rd_data;
  assign o_init_done = (q.st != C_INIT);
endmodule

// ==== design/drd_dev.sv ====
// Purpose: memory end of the link: two ranks of eight banks, BL8 bursts
// Assumes: clocked by the link beat clock; controller keeps spacing
// Notes: storage is a small flop array; row address is not stored
`timescale 1ns/1ps

// Functional notes
// R01 - read strobe toggles with each data beat
// R02 - controller centres write strobe in data eye
// R03 - termination strobe on x8 disables data mask
// R04 - two ranks, eight banks each, tracked apart
// R05 - one access is eight half-clock beats
// R06 - bursts start at column, follow programmed order
// R07 - activate opens bank row before column access
// R08 - chip select, bank, column pick burst target
// R09 - controller doubles refresh rate when hot
// R10 - upper ball group unused in x4 mode
// R11 - x8 mode has eight-bit two-way data bus
// R12 - deselected rank ignores every command
// R13 - masked write beats are not stored
// R14 - commands sampled on rising CK edge
// R15 - bank inputs pick bank or mode register
// R16 - controller tracks open row per bank
module drd_dev import drd_pkg::*; #(
  parameter int BLK_W = DEF_BLK_W
) (
  drd_link_if.dev lk,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire logic i_x8,
  output logic o_busy,
  output logic o_cmd_err,
  output logic o_tdqs_term,
  output logic [RANKS*BANKS-1:0] o_open_banks
);
  localparam int IDX_W = 1 + BA_W + BLK_W + 3;
  localparam int WORDS = 2 ** IDX_W;

  typedef struct packed {
    logic x8_m; // first sync stage of the width strap
    logic x8;
    logic [3:0][ADDR_W-1:0] mr;
    logic [RANKS*BANKS-1:0] open;
    drd_dev_st_t st;
    logic rd;
    logic [4:0] cnt;
    logic [2:0] b;
    logic [IDX_W-4:0] base;
    logic [2:0] start;
    logic [DQ_W-1:0] dq;
    logic [DQ_W-1:0] dq_oe;
    logic dqs;
    logic dqs_oe;
    logic err;
    logic [WORDS-1:0][DQ_W-1:0] mem;
  } drd_dev_s_t;

  drd_dev_s_t q;
  drd_dev_s_t d;
  logic [2:0] cmd;
  logic sel;
  logic il;
  logic tdqs_on;
  logic masked;
  logic [DQ_W-1:0] lane;
  logic [IDX_W-1:0] wi;
  logic [IDX_W-1:0] ri;

  // position of beat b inside an eight-word block, start column s
  function automatic logic [2:0] beat_pos(input logic [2:0] s, input logic [2:0] b, input logic i);
    logic [2:0] p;
    p = {s[2] ^ b[2], s[1:0] + b[1:0]}; // sequential wraps in each half
    if (i) begin
      p = s ^ b;
    end
    return p;
  endfunction

  // next state of the whole device
  always_comb begin
    d = q;
    d.err = 1'b0;
    d.x8_m = i_x8;
    d.x8 = q.x8_m;
    cmd = {lk.ras_n, lk.cas_n, lk.we_n};
    sel = lk.cs_n[0]; // rank 0 wins when both are selected
    il = q.mr[0][MR_ORDER_BIT];
    tdqs_on = q.x8 && q.mr[1][MR_TDQS_BIT]; // see R03
    masked = lk.dm && !tdqs_on; // see R03
    lane = q.x8 ? LANE_X8 : LANE_X4; // see R10
    wi = {q.base, beat_pos(q.start, q.b, il)};
    ri = {q.base, beat_pos(q.start, q.b + 3'h1, il)};

    // command decode only on beats where CK rises; see R14
    if (lk.ck) begin
      for (int r = 0; r < RANKS; r++) begin
        // a rank whose select is high sees nothing; see R12
        if (!lk.cs_n[r]) begin
          case (cmd)
            CMD_ACT: begin
              d.open[r * BANKS + int'(lk.ba)] = 1'b1; // see R07 R15
            end
            CMD_PRE: begin
              if (lk.addr[A10_BIT]) begin
                d.open[r * BANKS +: BANKS] = '0;
              end else begin
                d.open[r * BANKS + int'(lk.ba)] = 1'b0; // see R15
              end
            end
            CMD_MRS: begin
              d.mr[lk.ba[1:0]] = lk.addr; // see R15
            end
            default: begin
            end
          endcase
        end
      end
      // column command picks rank, bank and start column; see R08 R04
      if (lk.cs_n != CS_NONE && (cmd == CMD_RD || cmd == CMD_WR)) begin
        if (!q.open[{sel, lk.ba}] || q.st != DV_IDLE) begin
          d.err = 1'b1; // closed bank or burst in flight: dropped; see R07
        end else begin
          d.st = DV_WAIT;
          d.rd = (cmd == CMD_RD);
          d.cnt = ((cmd == CMD_RD) ? RL_BEATS : WL_BEATS) - 5'h01;
          d.base = {sel, lk.ba, lk.addr[BLK_W+2:3]};
          d.start = lk.addr[2:0]; // see R06
          d.b = 3'h0;
        end
      end
    end

    // burst engine: one beat per link clock, eight per access
    unique case (q.st)
      DV_IDLE: begin
      end
      DV_WAIT: begin
        d.cnt = q.cnt - 5'h01;
        if (q.cnt == 5'h00) begin
          d.st = DV_XFER;
          if (q.rd) begin
            // first beat leaves with a rising strobe edge; see R01
            d.dq = q.mem[{q.base, q.start}] & lane;
            d.dq_oe = lane; // see R10 R11
            d.dqs = 1'b1;
            d.dqs_oe = 1'b1;
          end
        end
      end
      DV_XFER: begin
        d.b = q.b + 3'h1; // see R05 R06
        if (!q.rd && !masked) begin
          // write beat stored unless masked; see R13
          if (q.x8) begin
            d.mem[wi] = lk.dq; // see R11
          end else begin
            d.mem[wi][3:0] = lk.dq[3:0]; // see R10
          end
        end
        if (q.rd) begin
          // data and strobe change on the same edge; see R01
          d.dq = q.mem[ri] & lane;
          d.dqs = ~q.dqs;
        end
        if (q.b == 3'h7) begin
          d.st = DV_IDLE;
          d.dq_oe = '0;
          d.dqs_oe = 1'b0;
          d.dq = '0;
          d.dqs = 1'b0;
        end
      end
    endcase

    // reset also clears the array, which costs time only in synthesis size
    if (i_rst) begin
      d = '0;
    end
  end

  // state register; clock enable freezes everything including reset
  always_ff @(posedge lk.dck) begin
    if (i_ce) begin
      q <= d;
    end
  end

  // pins and status
  assign lk.dev_dq = q.dq;
  assign lk.dev_dq_oe = q.dq_oe;
  assign lk.dev_dqs = q.dqs;
  assign lk.dev_dqs_oe = q.dqs_oe;
  assign lk.dev_tdqs = 1'b0;
  assign lk.dev_tdqs_oe = 1'b0; // termination only, never driven; see R03
  assign o_busy = (q.st != DV_IDLE);
  assign o_cmd_err = q.err;
  assign o_tdqs_term = q.x8 && q.mr[1][MR_TDQS_BIT];
  assign o_open_banks = q.open;
endmodule

// ==== design/drd_link_if.sv ====
// Purpose: pin-level link between controller and dual-rank memory
// Assumes: no tristate; shared wires resolved from the enables
// Notes: dck is the beat clock, ck the CK level made by the controller
`timescale 1ns/1ps
interface drd_link_if;
  import drd_pkg::*;
  logic dck;
  logic ck;
  logic [1:0] cs_n;
  logic ras_n;
  logic cas_n;
  logic we_n;
  logic [BA_W-1:0] ba;
  logic [ADDR_W-1:0] addr;
  logic dm;
  logic [DQ_W-1:0] ctl_dq;
  logic [DQ_W-1:0] ctl_dq_oe;
  logic ctl_dqs;
  logic ctl_dqs_oe;
  logic [DQ_W-1:0] dev_dq;
  logic [DQ_W-1:0] dev_dq_oe;
  logic dev_dqs;
  logic dev_dqs_oe;
  logic dev_tdqs;
  logic dev_tdqs_oe;
  logic [DQ_W-1:0] dq;
  logic dqs;
  logic dqs_n;
  // undriven dq and dqs read low; dqs_n then reads high
  assign dq = (dev_dq & dev_dq_oe) | (ctl_dq & ctl_dq_oe);
  assign dqs = (dev_dqs & dev_dqs_oe) | (ctl_dqs & ctl_dqs_oe);
  assign dqs_n = ~dqs;
  modport ctl (output dck, ck, cs_n, ras_n, cas_n, we_n, ba, addr, dm,
               output ctl_dq, ctl_dq_oe, ctl_dqs, ctl_dqs_oe,
               input dq, dqs, dqs_n);
  modport dev (input dck, ck, cs_n, ras_n, cas_n, we_n, ba, addr, dm,
               input dq, dqs, dqs_n,
               output dev_dq, dev_dq_oe, dev_dqs, dev_dqs_oe, dev_tdqs, dev_tdqs_oe);
endinterface

// ==== design/drd_pkg.sv ====
// Purpose: shared constants and types for the dual-rank DDR data link
// Assumes: controller clock 100 MHz; BL8 bursts only
// Notes: one link beat is one data transfer; two beats make one CK period
package drd_pkg;
  localparam int RANKS = 2;
  localparam int BANKS = 8;
  localparam int BA_W = 3;
  localparam int ADDR_W = 14;
  localparam int COL_W = 10;
  localparam int DQ_W = 8;
  localparam int BURST = 8; // 8n prefetch: beats per access
  localparam int DEF_BLK_W = 2; // column block address bits kept per bank: four blocks of eight words
  localparam int DEF_FIFO_DEPTH = 16;
  localparam int CL_CK = 5;
  localparam int CWL_CK = 5;
  localparam logic [4:0] RL_BEATS = 5'(2 * CL_CK);
  localparam logic [4:0] WL_BEATS = 5'(2 * CWL_CK);
  localparam logic [3:0] GAP_BEATS = 4'h8;
  localparam int CLK_MHZ = 100;
  localparam int REFI_NS = 7800;
  localparam int REFI_HOT_NS = 3900; // doubled rate above 85 C
  localparam logic [9:0] REFI_CYC = 10'(REFI_NS * CLK_MHZ / 1000);
  localparam logic [9:0] REFI_HOT_CYC = 10'(REFI_HOT_NS * CLK_MHZ / 1000);
  localparam int A10_BIT = 10; // all banks on precharge
  localparam int MR_ORDER_BIT = 3; // mode reg 0: interleaved order
  localparam int MR_TDQS_BIT = 11; // mode reg 1: termination strobe
  localparam int MR_SRT_BIT = 7; // mode reg 2: high-temp self refresh
  localparam logic [7:0] LANE_X8 = 8'hff;
  localparam logic [7:0] LANE_X4 = 8'h0f;
  // command code {ras_n, cas_n, we_n}
  localparam logic [2:0] CMD_MRS = 3'h0;
  localparam logic [2:0] CMD_REF = 3'h1;
  localparam logic [2:0] CMD_PRE = 3'h2;
  localparam logic [2:0] CMD_ACT = 3'h3;
  localparam logic [2:0] CMD_WR = 3'h4;
  localparam logic [2:0] CMD_RD = 3'h5;
  localparam logic [2:0] CMD_NOP = 3'h7;
  localparam logic [1:0] CS_NONE = 2'h3;
  localparam logic [1:0] CS_BOTH = 2'h0;
  typedef enum logic [1:0] {DV_IDLE, DV_WAIT, DV_XFER} drd_dev_st_t;
  typedef enum logic [2:0] {C_INIT, C_IDLE, C_PRE, C_ACT, C_COL, C_DATA, C_REF} drd_ctl_st_t;
endpackage

// ==== test/drd_link_properties.sv ====
// Purpose: protocol checks on the link between controller and memory end
// Assumes: sampled at beat clock rises; latencies from the package
// Notes: read bursts must be well formed and never meet a controller drive
`timescale 1ns/1ps
module drd_link_properties import drd_pkg::*; (
  input wire logic dck,
  input wire logic i_rst,
  input wire logic ck,
  input wire logic [1:0] cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic [DQ_W-1:0] ctl_dq_oe,
  input wire logic ctl_dqs_oe,
  input wire logic [DQ_W-1:0] dev_dq_oe,
  input wire logic dev_dqs,
  input wire logic dev_dqs_oe,
  input wire logic dev_tdqs,
  input wire logic dev_tdqs_oe
);
  default clocking @(posedge dck); endclocking
  default disable iff (i_rst);
  // commands count only where the memory end takes them, with ck high
  sequence rd_cmd_s;
    ck && cs_n != CS_NONE && {ras_n, cas_n, we_n} == CMD_RD;
  endsequence
  sequence wr_cmd_s;
    ck && cs_n != CS_NONE && {ras_n, cas_n, we_n} == CMD_WR;
  endsequence
  sequence rd_burst_s;
    dev_dqs_oe [*8] ##1 !dev_dqs_oe;
  endsequence
  rd_first_high_a: assert property ($rose(dev_dqs_oe) |-> dev_dqs)
    else $error("read strobe did not open high");
  rd_strobe_tog_a: assert property (dev_dqs_oe && $past(dev_dqs_oe) |-> dev_dqs != $past(dev_dqs))
    else $error("read strobe missed a toggle");
  rd_burst_len_a: assert property ($rose(dev_dqs_oe) |-> rd_burst_s)
    else $error("read burst not eight beats");
  rd_latency_a: assert property (rd_cmd_s |-> ##[10:11] $rose(dev_dqs_oe))
    else $error("read data late or missing");
  dq_with_dqs_a: assert property ((dev_dq_oe != 8'h00) == dev_dqs_oe)
    else $error("read data and strobe drive differ");
  no_contend_a: assert property (dev_dqs_oe |-> !ctl_dqs_oe && ctl_dq_oe == 8'h00)
    else $error("both ends drive the data bus");
  wr_strobe_a: assert property (wr_cmd_s |-> ##[8:12] ctl_dqs_oe)
    else $error("write strobe not driven after write");
  cmd_hold_a: assert property (cs_n != CS_NONE |-> ck ##1 (cs_n == CS_NONE && !ck))
    else $error("command not held for one beat at a CK rise");
  tdqs_quiet_a: assert property (!dev_tdqs_oe && !dev_tdqs)
    else $error("termination strobe driven");
endmodule

// ==== test/test_dual_rank_ddr3_data_interface.sv ====
// Purpose: end-to-end bench, controller and memory end joined by the link
// Assumes: modes are changed through a reset so they reach the mode registers
// Notes: a bench copy of the array predicts every read beat
`timescale 1ns/1ps
module test_dual_rank_ddr3_data_interface import drd_pkg::*;;
  logic i_ref_clk, i_rst = 1'b1, i_req_valid = 1'b0, i_req_wr = 1'b0, i_req_rank = 1'b0;
  logic i_wd_valid = 1'b0, i_wd_mask = 1'b0, i_x8 = 1'b1, i_tdqs_en = 1'b0, i_interleave = 1'b0, i_hot = 1'b0;
  logic [BA_W-1:0] i_req_bank = 3'h0;
  logic [ADDR_W-1:0] i_req_row = 14'h0000;
  logic [COL_W-1:0] i_req_col = 10'h000;
  logic [DQ_W-1:0] i_wd_data = 8'h00, o_rd_data;
  logic o_req_ready, o_wd_ready, o_rd_valid, o_init_done, o_busy, o_cmd_err, o_tdqs_term;
  logic [RANKS*BANKS-1:0] o_open_banks;
  int num_errors = 0, n_tests = 0, cyc = 0, ref_n = 0, ref_prev = 0, ref_last = 0;
  logic [7:0] mem [512];
  logic [7:0] rd_q [$];
  drd_link_if lk();
  drd_ctl #(.FIFO_DEPTH(DEF_FIFO_DEPTH)) i_drd_ctl (.lk(lk), .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_ce(1'b1),
    .i_req_valid(i_req_valid), .o_req_ready(o_req_ready), .i_req_wr(i_req_wr), .i_req_rank(i_req_rank),
    .i_req_bank(i_req_bank), .i_req_row(i_req_row), .i_req_col(i_req_col), .i_wd_valid(i_wd_valid),
    .o_wd_ready(o_wd_ready), .i_wd_data(i_wd_data), .i_wd_mask(i_wd_mask), .o_rd_valid(o_rd_valid),
    .o_rd_data(o_rd_data), .i_x8(i_x8), .i_tdqs_en(i_tdqs_en), .i_interleave(i_interleave), .i_hot(i_hot),
    .o_init_done(o_init_done));
  drd_dev #(.BLK_W(DEF_BLK_W)) i_drd_dev (.lk(lk), .i_rst(i_rst), .i_ce(1'b1), .i_x8(i_x8), .o_busy(o_busy),
    .o_cmd_err(o_cmd_err), .o_tdqs_term(o_tdqs_term), .o_open_banks(o_open_banks));
  drd_link_properties i_drd_link_properties (.dck(lk.dck), .i_rst(i_rst), .ck(lk.ck), .cs_n(lk.cs_n),
    .ras_n(lk.ras_n), .cas_n(lk.cas_n), .we_n(lk.we_n), .ctl_dq_oe(lk.ctl_dq_oe), .ctl_dqs_oe(lk.ctl_dqs_oe),
    .dev_dq_oe(lk.dev_dq_oe), .dev_dqs(lk.dev_dqs), .dev_dqs_oe(lk.dev_dqs_oe), .dev_tdqs(lk.dev_tdqs),
    .dev_tdqs_oe(lk.dev_tdqs_oe));
  // 100 MHz reference clock
  initial begin
    i_ref_clk = 1'b0;
    forever #5 i_ref_clk = ~i_ref_clk;
  end
  // cycle count and read beat capture; no back-pressure on read return
  always @(posedge i_ref_clk) begin
    cyc <= cyc + 1;
    if (o_rd_valid === 1'b1) rd_q.push_back(o_rd_data);
  end
  // refresh spacing, seen on rank 0 where the memory end takes commands
  always @(posedge lk.dck) begin
    if (!i_rst && lk.ck && !lk.cs_n[0] && {lk.ras_n, lk.cas_n, lk.we_n} == CMD_REF) begin
      ref_prev <= ref_last;
      ref_last <= cyc;
      ref_n <= ref_n + 1;
    end
    if (!i_rst && o_cmd_err === 1'b1) begin
      num_errors++;
      $display("unexpected command error at %0t: %h vs %h", $time, o_cmd_err, 1'b0);
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // array slot of beat j: sequential order keeps bit 2 apart, interleave xors all three
  function automatic logic [8:0] slot(logic rk, logic [2:0] bk, logic [9:0] col, int j);
    logic [2:0] b;
    b = 3'(j);
    return {rk, bk, col[4:3], i_interleave ? (col[2:0] ^ b) : {col[2] ^ b[2], col[1:0] + b[1:0]}};
  endfunction
  // mode straps only reach the mode registers through a fresh init
  task automatic set(input logic ilv, input logic td, input logic x8);
    int n;
    n = 0;
    @(posedge i_ref_clk);
    i_rst <= 1'b1;
    i_interleave <= ilv;
    i_tdqs_en <= td;
    i_x8 <= x8;
    repeat (6) @(posedge i_ref_clk);
    i_rst <= 1'b0;
    foreach (mem[k]) mem[k] = 8'h00;
    repeat (2) @(posedge i_ref_clk);
    while (o_init_done !== 1'b1 && n < 2000) begin
      @(posedge i_ref_clk);
      n++;
    end
  endtask
  // request held until ready seen high before the taking edge
  task automatic req(input logic wr, input logic rk, input logic [2:0] bk, input logic [9:0] col);
    int n;
    n = 0;
    @(posedge i_ref_clk);
    i_req_valid <= 1'b1;
    i_req_wr <= wr;
    i_req_rank <= rk;
    i_req_bank <= bk;
    i_req_col <= col;
    i_req_row <= 14'h0100 + 14'(col);
    do begin
      @(negedge i_ref_clk);
      n++;
    end while (o_req_ready !== 1'b1 && n < 4000);
    @(posedge i_ref_clk);
    i_req_valid <= 1'b0;
    chk(n < 4000, 1'b1);
  endtask
  task automatic push(input logic [7:0] d, input logic m);
    int n;
    n = 0;
    i_wd_valid <= 1'b1;
    i_wd_data <= d;
    i_wd_mask <= m;
    do begin
      @(negedge i_ref_clk);
      n++;
    end while (o_wd_ready !== 1'b1 && n < 1000);
    @(posedge i_ref_clk);
  endtask
  // eight words into the FIFO, then the write request; mask bit j covers beat j
  task automatic wr(input logic rk, input logic [2:0] bk, input logic [9:0] col, input logic [7:0] base,
                    input logic [7:0] mask);
    @(posedge i_ref_clk);
    for (int j = 0; j < 8; j++) begin
      push(base + 8'(j * 17), mask[j]);
      if (!mask[j] || (i_tdqs_en && i_x8)) mem[slot(rk, bk, col, j)] = base + 8'(j * 17);
    end
    i_wd_valid <= 1'b0;
    req(1'b1, rk, bk, col);
  endtask
  task automatic rd(input logic rk, input logic [2:0] bk, input logic [9:0] col);
    int n;
    n = 0;
    rd_q = {};
    req(1'b0, rk, bk, col);
    while (rd_q.size() < 8 && n < 300) begin
      @(posedge i_ref_clk);
      n++;
    end
    while (rd_q.size() < 8) rd_q.push_back(8'hxx);
    for (int j = 0; j < 8; j++) chk(rd_q[j], mem[slot(rk, bk, col, j)] & (i_x8 ? 8'hff : 8'h0f));
  endtask
  // gap between the last two refreshes once three new ones were seen
  task automatic refi(input int exp);
    int n0, k, gap;
    n0 = ref_n;
    k = 0;
    while (ref_n < n0 + 3 && k < 3000) begin
      @(posedge i_ref_clk);
      k++;
    end
    gap = ref_last - ref_prev;
    chk((gap + 8 >= exp && gap <= exp + 8) ? exp : gap, exp);
  endtask
  task finish_test;
    $display("mismatches %0d, comparisons %0d", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // main sequence
  initial begin
    set(1'b0, 1'b0, 1'b1);
    wr(1'b0, 3'h0, 10'h000, 8'h10, 8'h00);
    wr(1'b1, 3'h0, 10'h000, 8'h80, 8'h00);
    rd(1'b0, 3'h0, 10'h000);
    rd(1'b1, 3'h0, 10'h000);
    chk(o_open_banks, 32'h00000101);
    chk(o_busy, 1'b0);
    wr(1'b0, 3'h5, 10'h00d, 8'h21, 8'h24);
    rd(1'b0, 3'h5, 10'h00a);
    refi(780);
    @(posedge i_ref_clk);
    i_hot <= 1'b1;
    refi(390);
    rd(1'b0, 3'h5, 10'h00f);
    set(1'b1, 1'b0, 1'b1);
    wr(1'b1, 3'h7, 10'h01b, 8'h33, 8'h00);
    rd(1'b1, 3'h7, 10'h01e);
    set(1'b0, 1'b1, 1'b1);
    chk(o_tdqs_term, 1'b1);
    wr(1'b0, 3'h2, 10'h004, 8'h44, 8'hff);
    rd(1'b0, 3'h2, 10'h000);
    set(1'b0, 1'b0, 1'b0);
    wr(1'b1, 3'h1, 10'h000, 8'hf5, 8'h00);
    rd(1'b1, 3'h1, 10'h000);
    finish_test();
  end
  // watchdog, well past the expected run length
  initial begin
    #800000;
    num_errors++;
    $display("unexpected hang at %0t: %h vs %h", $time, 1'b0, 1'b1);
    finish_test();
  end
endmodule
